// ===== common/ssw_pkg.sv
`default_nettype none
package ssw_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // status word bit positions, byte 1 sits at bits 15:8
  localparam int unsigned B_DIAG      = 0;
  localparam int unsigned B_CFG_CHG   = 3;
  localparam int unsigned B_LOAD_LOW  = 7;
  localparam int unsigned B_SYS_HIGH  = 8;
  localparam int unsigned B_SYS_LOW   = 9;
  localparam int unsigned B_MBUS_LOST = 10;
  localparam int unsigned B_CFG_BAD   = 11;
  localparam int unsigned B_WDG       = 12;
  localparam int unsigned B_FORCE     = 14;

  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_USED   = 16'h5F89;

  // thresholds in millivolts
  localparam logic [15:0] LOAD_LOW_MV = 16'h4650;  // 18000 mV
  localparam logic [15:0] SYS_HIGH_MV = 16'h7530;  // 30000 mV
  localparam logic [15:0] SYS_LOW_MV  = 16'h4650;  // 18000 mV

  localparam int unsigned MBUS_TIMEOUT_US = 100;
  localparam logic [15:0] MBUS_TIMEOUT_CYC =
    16'(MBUS_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WDG_TIME_MS = 500;
  localparam int unsigned WDG_CYC = WDG_TIME_MS * (CLK_HZ / 1000);

  localparam logic [3:0]  SW_FACTORY_POS = 4'hF;
  localparam logic [63:0] PW_DEFAULT     = 64'h7061_7373_776F_7264;

  typedef enum logic [1:0] {
    PROTO_REG = 2'b00,
    PROTO_OBJ = 2'b01,
    PROTO_CYC = 2'b10
  } ssw_proto_t;

  typedef enum logic [1:0] {
    WDG_IDLE    = 2'b00,
    WDG_RUN     = 2'b01,
    WDG_EXPIRED = 2'b10
  } ssw_wdg_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] load_mv;
    logic [15:0] sys_mv;
  } ssw_meas_t;

  typedef struct packed {
    logic        mapped;
    logic [15:0] status;
    logic [15:0] control;
  } ssw_pd_t;

endpackage
`default_nettype wire

// ===== rtl/ssw_sync.sv
`default_nettype none
module ssw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ssw_factory.sv
`default_nettype none
module ssw_factory (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [3:0]  sw_pos,
  input  wire logic        pw_wr,
  input  wire logic [63:0] pw_data,
  output logic      [63:0] admin_pw,
  output logic             restore
);
  logic        match_q;
  logic        match_d;
  logic        restore_d;
  logic [63:0] pw_d;

  // only entry into the reset position fires, so a switch left there
  // does not keep wiping a password set afterwards
  always_comb begin
    match_d   = match_q;
    restore_d = 1'b0;
    pw_d      = admin_pw;
    if (ce) begin
      match_d   = (sw_pos == ssw_pkg::SW_FACTORY_POS);
      restore_d = match_d && !match_q;
      if (restore_d) begin
        pw_d = ssw_pkg::PW_DEFAULT;
      end else if (pw_wr) begin
        pw_d = pw_data;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      match_q  <= 1'b0;
      restore  <= 1'b0;
      admin_pw <= ssw_pkg::PW_DEFAULT;
    end else begin
      match_q  <= match_d;
      restore  <= restore_d;
      admin_pw <= pw_d;
    end
  end

  AST_PW_RESTORE: assert property (
    @(posedge mclk) disable iff (!resetn)
    restore |-> admin_pw == ssw_pkg::PW_DEFAULT
  ) else $error("restore left password unchanged");

  AST_PW_ENTRY: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && sw_pos == ssw_pkg::SW_FACTORY_POS && !match_q |=> restore
  ) else $error("switch entry did not restore");
endmodule
`default_nettype wire

// ===== rtl/ssw_top.sv
`default_nettype none
module ssw_top #(
  parameter int unsigned WDG_CYCLES = ssw_pkg::WDG_CYC
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire logic                diag_pin,
  input  wire logic                force_pin,
  input  wire logic                mbus_act_pin,
  input  wire logic [3:0]          sw_pos_pin,
  input  wire ssw_pkg::ssw_meas_t  meas,
  input  wire logic                cfg_scan_valid,
  input  wire logic [15:0]         cfg_scan_sig,
  input  wire logic [15:0]         cfg_expect_sig,
  input  wire ssw_pkg::ssw_proto_t proto,
  input  wire logic                map_disable,
  input  wire logic                fb_frame,
  input  wire logic                pd_ctrl_wr,
  input  wire logic [15:0]         pd_ctrl_data,
  input  wire logic                pw_wr,
  input  wire logic [63:0]         pw_data,
  output ssw_pkg::ssw_pd_t         pd_out,
  output logic [15:0]              station_status,
  output logic [63:0]              admin_pw,
  output logic                     factory_restore
);

  function automatic logic below(input logic [15:0] v,
                                 input logic [15:0] th);
    below = v < th;
  endfunction

  logic       diag_s;
  logic       force_s;
  logic       act_s;
  logic [3:0] sw_s;

  ssw_sync #(.W(3)) u_sync_lvl (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      ({diag_pin, force_pin, mbus_act_pin}),
    .q      ({diag_s, force_s, act_s})
  );

  ssw_sync #(.W(4)) u_sync_sw (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .d      (sw_pos_pin),
    .q      (sw_s)
  );

  ssw_factory u_factory (
    .mclk     (mclk),
    .resetn   (resetn),
    .ce       (ce),
    .sw_pos   (sw_s),
    .pw_wr    (pw_wr),
    .pw_data  (pw_data),
    .admin_pw (admin_pw),
    .restore  (factory_restore)
  );

  // supply monitor, flags hold between measurements
  logic load_low_q, load_low_d;
  logic sys_high_q, sys_high_d;
  logic sys_low_q,  sys_low_d;

  always_comb begin
    load_low_d = load_low_q;
    sys_high_d = sys_high_q;
    sys_low_d  = sys_low_q;
    if (ce && meas.valid) begin
      load_low_d = below(meas.load_mv, ssw_pkg::LOAD_LOW_MV);
      sys_high_d = below(ssw_pkg::SYS_HIGH_MV, meas.sys_mv);
      sys_low_d  = below(meas.sys_mv, ssw_pkg::SYS_LOW_MV);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      load_low_q <= 1'b0;
      sys_high_q <= 1'b0;
      sys_low_q  <= 1'b0;
    end else begin
      load_low_q <= load_low_d;
      sys_high_q <= sys_high_d;
      sys_low_q  <= sys_low_d;
    end
  end

  // station configuration tracking
  logic [15:0] prev_sig_q, prev_sig_d;
  logic        have_prev_q, have_prev_d;
  logic        cfg_chg_q, cfg_chg_d;
  logic        cfg_bad_q, cfg_bad_d;

  // the first scan has nothing to differ from, so no warning then
  always_comb begin
    prev_sig_d  = prev_sig_q;
    have_prev_d = have_prev_q;
    cfg_chg_d   = cfg_chg_q;
    cfg_bad_d   = cfg_bad_q;
    if (ce && cfg_scan_valid) begin
      cfg_chg_d   = have_prev_q && (cfg_scan_sig != prev_sig_q);
      cfg_bad_d   = cfg_scan_sig != cfg_expect_sig;
      prev_sig_d  = cfg_scan_sig;
      have_prev_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_sig_q  <= 16'h0000;
      have_prev_q <= 1'b0;
      cfg_chg_q   <= 1'b0;
      cfg_bad_q   <= 1'b0;
    end else begin
      prev_sig_q  <= prev_sig_d;
      have_prev_q <= have_prev_d;
      cfg_chg_q   <= cfg_chg_d;
      cfg_bad_q   <= cfg_bad_d;
    end
  end

  // module bus silence: any edge on the activity line restarts the count
  logic        act_prev_q, act_prev_d;
  logic [15:0] mbus_cnt_q, mbus_cnt_d;
  logic        act_edge;
  logic        mbus_lost;

  assign act_edge  = act_s != act_prev_q;
  assign mbus_lost = mbus_cnt_q == ssw_pkg::MBUS_TIMEOUT_CYC;

  always_comb begin
    act_prev_d = act_prev_q;
    mbus_cnt_d = mbus_cnt_q;
    if (ce) begin
      act_prev_d = act_s;
      if (act_edge) begin
        mbus_cnt_d = 16'h0000;
      end else if (!mbus_lost) begin
        mbus_cnt_d = mbus_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      act_prev_q <= 1'b0;
      mbus_cnt_q <= 16'h0000;
    end else begin
      act_prev_q <= act_prev_d;
      mbus_cnt_q <= mbus_cnt_d;
    end
  end

  // fieldbus watchdog, armed by the first frame under the register
  // protocol; other protocols keep it idle so the flag cannot show
  ssw_pkg::ssw_wdg_t wdg_q, wdg_d;
  logic [31:0]       wdg_cnt_q, wdg_cnt_d;
  logic              is_reg;

  assign is_reg = proto == ssw_pkg::PROTO_REG;

  always_comb begin
    wdg_d     = wdg_q;
    wdg_cnt_d = wdg_cnt_q;
    if (ce) begin
      case (wdg_q)
        ssw_pkg::WDG_IDLE: begin
          wdg_cnt_d = 32'h0000_0000;
          if (is_reg && fb_frame) begin
            wdg_d = ssw_pkg::WDG_RUN;
          end
        end
        ssw_pkg::WDG_RUN: begin
          if (!is_reg) begin
            wdg_d = ssw_pkg::WDG_IDLE;
          end else if (fb_frame) begin
            wdg_cnt_d = 32'h0000_0000;
          end else if (wdg_cnt_q == 32'(WDG_CYCLES - 1)) begin
            wdg_d = ssw_pkg::WDG_EXPIRED;
          end else begin
            wdg_cnt_d = wdg_cnt_q + 32'h0000_0001;
          end
        end
        ssw_pkg::WDG_EXPIRED: begin
          wdg_cnt_d = 32'h0000_0000;
          if (!is_reg) begin
            wdg_d = ssw_pkg::WDG_IDLE;
          end else if (fb_frame) begin
            wdg_d = ssw_pkg::WDG_RUN;
          end
        end
        default: begin
          wdg_d     = ssw_pkg::WDG_IDLE;
          wdg_cnt_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdg_q     <= ssw_pkg::WDG_IDLE;
      wdg_cnt_q <= 32'h0000_0000;
    end else begin
      wdg_q     <= wdg_d;
      wdg_cnt_q <= wdg_cnt_d;
    end
  end

  // status word and process data image
  logic [15:0]      status_d;
  ssw_pkg::ssw_pd_t pd_d;

  always_comb begin
    status_d = station_status;
    pd_d     = pd_out;
    if (ce) begin
      status_d = ssw_pkg::STATUS_RESET;
      status_d[ssw_pkg::B_DIAG]      = diag_s;
      status_d[ssw_pkg::B_CFG_CHG]   = cfg_chg_q;
      status_d[ssw_pkg::B_LOAD_LOW]  = load_low_q;
      status_d[ssw_pkg::B_SYS_HIGH]  = sys_high_q;
      status_d[ssw_pkg::B_SYS_LOW]   = sys_low_q;
      status_d[ssw_pkg::B_MBUS_LOST] = mbus_lost;
      status_d[ssw_pkg::B_CFG_BAD]   = cfg_bad_q;
      status_d[ssw_pkg::B_WDG]       =
        wdg_q == ssw_pkg::WDG_EXPIRED;
      status_d[ssw_pkg::B_FORCE]     = force_s;
      pd_d.mapped  = !(proto == ssw_pkg::PROTO_OBJ && map_disable);
      pd_d.status  = pd_d.mapped ? status_d : 16'h0000;
      // control word is reserved: incoming writes never reach it
      pd_d.control = ssw_pkg::CONTROL_RESET;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      station_status <= ssw_pkg::STATUS_RESET;
      pd_out         <= '{mapped: 1'b1, status: ssw_pkg::STATUS_RESET,
                          control: ssw_pkg::CONTROL_RESET};
    end else begin
      station_status <= status_d;
      pd_out         <= pd_d;
    end
  end

  AST_DIAG: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce |=> station_status[ssw_pkg::B_DIAG] == $past(diag_s)
  ) else $error("diagnosis bit does not follow modules");

  AST_CFG_CHG: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && cfg_scan_valid && have_prev_q && cfg_scan_sig != prev_sig_q
    ##1 ce |=> station_status[ssw_pkg::B_CFG_CHG]
  ) else $error("configuration change not flagged");

  AST_LOAD_LOW: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && meas.valid && meas.load_mv < ssw_pkg::LOAD_LOW_MV ##1 ce
    |=> station_status[ssw_pkg::B_LOAD_LOW]
  ) else $error("load supply low not flagged");

  AST_SYS_RANGE: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && meas.valid ##1 ce |=>
    station_status[ssw_pkg::B_SYS_HIGH] ==
      ($past(meas.sys_mv, 2) > ssw_pkg::SYS_HIGH_MV) &&
    station_status[ssw_pkg::B_SYS_LOW] ==
      ($past(meas.sys_mv, 2) < ssw_pkg::SYS_LOW_MV)
  ) else $error("system supply flags wrong");

  AST_MBUS: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && act_edge |=> !mbus_lost
  ) else $error("module bus activity did not clear loss");

  AST_CFG_BAD: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && cfg_scan_valid ##1 ce |=>
    station_status[ssw_pkg::B_CFG_BAD] ==
      ($past(cfg_scan_sig, 2) != $past(cfg_expect_sig, 2))
  ) else $error("incompatible configuration flag wrong");

  AST_WDG_PROTO: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && !is_reg |=> wdg_q == ssw_pkg::WDG_IDLE
  ) else $error("watchdog active outside register protocol");

  AST_FORCE: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce |=> station_status[ssw_pkg::B_FORCE] == $past(force_s)
  ) else $error("force bit does not follow force mode");

  AST_CTRL: assert property (
    @(posedge mclk) disable iff (!resetn)
    pd_ctrl_wr && pd_ctrl_data != 16'h0000 |=>
    pd_out.control == ssw_pkg::CONTROL_RESET
  ) else $error("control word write took effect");

  AST_RSVD: assert property (
    @(posedge mclk) disable iff (!resetn)
    (station_status & ~ssw_pkg::STATUS_USED) == 16'h0000
  ) else $error("unassigned status bit set");

  AST_MAP: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce |=> pd_out.mapped ==
      !($past(proto) == ssw_pkg::PROTO_OBJ && $past(map_disable)) &&
    pd_out.status == (pd_out.mapped ? station_status : 16'h0000)
  ) else $error("process data mapping wrong");

endmodule
`default_nettype wire

// ===== verif/ssw_fb_model.sv
`default_nettype none
module ssw_fb_model (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             run,
  input  wire logic [7:0]       period,
  input  wire ssw_pkg::ssw_pd_t pd_out,
  output logic                  fb_frame,
  output logic                  pd_ctrl_wr,
  output logic [15:0]           pd_ctrl_data,
  output ssw_pkg::ssw_pd_t      pd_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt;

  // data lines churn every cycle so a stale control word never looks held
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      fb_frame <= 1'b0;
      pd_ctrl_wr <= 1'b0;
      pd_ctrl_data <= 16'hA5A5;
      pd_seen <= '0;
    end else begin
      fb_frame <= 1'b0;
      pd_ctrl_wr <= 1'b0;
      pd_ctrl_data <= pd_ctrl_data + 16'h1357;
      if (run) begin
        if (cnt + 8'h01 >= period) begin
          cnt <= 8'h00;
          fb_frame <= 1'b1;
          pd_ctrl_wr <= 1'b1;
          pd_seen <= pd_out;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned WDG_T = 20;

  logic               mclk, resetn, ce, diag_pin, force_pin, mbus_act_pin;
  logic               cfg_scan_valid, map_disable, pw_wr, fb_frame;
  logic               pd_ctrl_wr, factory_restore, fb_run, mbus_run, exp_map;
  logic [3:0]         sw_pos_pin;
  logic [7:0]         fb_period;
  logic [15:0]        cfg_scan_sig, cfg_expect_sig, pd_ctrl_data;
  logic [15:0]        station_status, exp_s;
  logic [63:0]        pw_data, admin_pw;
  ssw_pkg::ssw_meas_t meas;
  ssw_pkg::ssw_proto_t proto;
  ssw_pkg::ssw_pd_t   pd_out, pd_seen;
  int                 miscompares, tests_run, k;
  logic [15:0]        ld [5] = '{16'h464F, 16'h4650, 16'h4650, 16'h4650,
                                 16'h5DC0};
  logic [15:0]        sy [5] = '{16'h5DC0, 16'h7531, 16'h7530, 16'h464F,
                                 16'h4650};
  logic [15:0]        ex [5] = '{16'h0080, 16'h0100, 16'h0000, 16'h0200,
                                 16'h0000};

  ssw_top #(.WDG_CYCLES(WDG_T)) u_dut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .diag_pin(diag_pin),
    .force_pin(force_pin), .mbus_act_pin(mbus_act_pin),
    .sw_pos_pin(sw_pos_pin), .meas(meas), .cfg_scan_valid(cfg_scan_valid),
    .cfg_scan_sig(cfg_scan_sig), .cfg_expect_sig(cfg_expect_sig),
    .proto(proto), .map_disable(map_disable), .fb_frame(fb_frame),
    .pd_ctrl_wr(pd_ctrl_wr), .pd_ctrl_data(pd_ctrl_data), .pw_wr(pw_wr),
    .pw_data(pw_data), .pd_out(pd_out), .station_status(station_status),
    .admin_pw(admin_pw), .factory_restore(factory_restore)
  );

  ssw_fb_model u_fb (
    .mclk(mclk), .resetn(resetn), .run(fb_run), .period(fb_period),
    .pd_out(pd_out), .fb_frame(fb_frame), .pd_ctrl_wr(pd_ctrl_wr),
    .pd_ctrl_data(pd_ctrl_data), .pd_seen(pd_seen)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // steady toggling keeps the module bus looking alive
  always @(posedge mclk) begin
    if (mbus_run) mbus_act_pin <= ~mbus_act_pin;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_stat();
    #1;
    check(64'(station_status), 64'(exp_s));
    check(64'(pd_out.mapped), 64'(exp_map));
    check(64'(pd_out.status), exp_map ? 64'(exp_s) : 64'h0);
    check(64'(pd_out.control), 64'h0);
  endtask

  task automatic pin_step(input logic d, input logic f, input logic [15:0] e);
    @(posedge mclk);
    diag_pin <= d;
    force_pin <= f;
    tick(3);
    exp_s = e;
    chk_stat();
  endtask

  task automatic meas_put(input logic [15:0] l, input logic [15:0] s,
                          input logic [15:0] e);
    @(posedge mclk);
    meas <= '{1'b1, l, s};
    @(posedge mclk);
    meas.valid <= 1'b0;
    tick(1);
    exp_s = e;
    chk_stat();
  endtask

  task automatic scan(input logic [15:0] sig, input logic [15:0] e);
    @(posedge mclk);
    cfg_scan_valid <= 1'b1;
    cfg_scan_sig <= sig;
    @(posedge mclk);
    cfg_scan_valid <= 1'b0;
    tick(1);
    exp_s = e;
    chk_stat();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // whole sequence needs about 1300 cycles
  initial begin
    tick(5000);
    miscompares++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0; ce = 1'b1; diag_pin = 1'b0; force_pin = 1'b0;
    mbus_act_pin = 1'b0; mbus_run = 1'b1; sw_pos_pin = 4'h0;
    meas = '0; cfg_scan_valid = 1'b0; cfg_scan_sig = 16'h0000;
    cfg_expect_sig = 16'h1234; proto = ssw_pkg::PROTO_REG;
    map_disable = 1'b0; pw_wr = 1'b0; pw_data = 64'h0;
    fb_run = 1'b0; fb_period = 8'h05; exp_s = 16'h0000; exp_map = 1'b1;
    miscompares = 0; tests_run = 0;
    tick(8);
    resetn <= 1'b1;
    tick(10);
    chk_stat();
    check(admin_pw, ssw_pkg::PW_DEFAULT);
    pin_step(1'b1, 1'b0, 16'h0001);
    pin_step(1'b1, 1'b1, 16'h4001);
    pin_step(1'b0, 1'b0, 16'h0000);
    // clock enable low must freeze the synchronisers too
    @(posedge mclk);
    ce <= 1'b0;
    diag_pin <= 1'b1;
    tick(6);
    chk_stat();
    @(posedge mclk);
    ce <= 1'b1;
    tick(3);
    exp_s = 16'h0001;
    chk_stat();
    pin_step(1'b0, 1'b0, 16'h0000);
    for (int i = 0; i < 5; i++) meas_put(ld[i], sy[i], ex[i]);
    scan(16'h1234, 16'h0000);
    scan(16'h5678, 16'h0808);
    scan(16'h5678, 16'h0800);
    scan(16'h1234, 16'h0008);
    scan(16'h1234, 16'h0000);
    @(posedge mclk);
    mbus_run <= 1'b0;
    tick(1010);
    exp_s = 16'h0400;
    chk_stat();
    @(posedge mclk);
    mbus_run <= 1'b1;
    tick(8);
    exp_s = 16'h0000;
    chk_stat();
    // nonzero status while frames run, so the far side's copy can differ
    @(posedge mclk);
    fb_run <= 1'b1;
    diag_pin <= 1'b1;
    tick(60);
    exp_s = 16'h0001;
    chk_stat();
    check(64'(pd_seen.status), 64'(exp_s));
    @(posedge mclk);
    fb_period <= 8'h0F;
    diag_pin <= 1'b0;
    tick(60);
    exp_s = 16'h0000;
    chk_stat();
    @(posedge mclk);
    fb_run <= 1'b0;
    tick(30);
    exp_s = 16'h1000;
    chk_stat();
    @(posedge mclk);
    fb_period <= 8'h05;
    fb_run <= 1'b1;
    tick(10);
    exp_s = 16'h0000;
    chk_stat();
    @(posedge mclk);
    fb_run <= 1'b0;
    tick(30);
    exp_s = 16'h1000;
    chk_stat();
    @(posedge mclk);
    proto <= ssw_pkg::PROTO_OBJ;
    tick(3);
    exp_s = 16'h0000;
    chk_stat();
    pin_step(1'b1, 1'b0, 16'h0001);
    @(posedge mclk);
    map_disable <= 1'b1;
    tick(2);
    exp_map = 1'b0;
    chk_stat();
    @(posedge mclk);
    proto <= ssw_pkg::PROTO_CYC;
    tick(2);
    exp_map = 1'b1;
    chk_stat();
    @(posedge mclk);
    pw_wr <= 1'b1;
    pw_data <= 64'h0123_4567_89AB_CDEF;
    @(posedge mclk);
    pw_wr <= 1'b0;
    #1;
    check(admin_pw, 64'h0123_4567_89AB_CDEF);
    @(posedge mclk);
    sw_pos_pin <= ssw_pkg::SW_FACTORY_POS;
    k = 0;
    do begin
      tick(1);
      #1;
      k++;
    end while (factory_restore !== 1'b1 && k < 10);
    check(64'(factory_restore), 64'h1);
    check(admin_pw, ssw_pkg::PW_DEFAULT);
    wrap_up();
  end
endmodule
`default_nettype wire
